// >>> hdl/sdrpw_core.sv
// sdram power/refresh block: init tracking, self refresh, power-down gating
// assumes controller pins arrive asynchronously and pass a two-stage synchroniser
`timescale 1ns/1ps
`include "sdrpw_map.svh"
module sdrpw_core
   import sdrpw_pkg::*;
#(
   parameter int ROWS_W       = 12,
   parameter int ROW_INTERVAL = `SDRPW_ROW_INTERVAL_CYC
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                cke_pin,
   input  wire sdrpw_pkg::sdrpw_cmd_s cmd_pin,
   output logic                     dq_oe,
   output logic                     cmd_accept,
   output sdrpw_pkg::sdrpw_cmd_s    cmd_seen,
   output logic                     self_refresh_active,
   output logic                     power_down_active,
   output logic                     refresh_tick,
   output logic [ROWS_W-1:0]        refresh_row,
   output logic                     init_done
);
   import sdrpw_pkg::*;

   // timer wide enough to hold one row interval
   localparam int ICW = $clog2(ROW_INTERVAL + 1);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic       cke_m_q;
   logic       cke_s_q;
   logic       cke_p_q;
   sdrpw_cmd_s cmd_m_q;
   sdrpw_cmd_s cmd_s_q;

   // reset values look like a deselected bus with clock-enable low
   // cke_p_q is one stage more, used to find the falling edge and to gate command sampling
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cke_m_q <= 1'b0;
         cke_s_q <= 1'b0;
         cke_p_q <= 1'b0;
         cmd_m_q <= '1;
         cmd_s_q <= '1;
      end else begin
         cke_m_q <= cke_pin;
         cke_s_q <= cke_m_q;
         cke_p_q <= cke_s_q;
         cmd_m_q <= cmd_pin;
         cmd_s_q <= cmd_m_q;
      end
   end

   // matches the four strobes against one command code
   function automatic logic is_cmd(input sdrpw_cmd_s c, input logic [3:0] code);
      is_cmd = ({c.cs_n, c.ras_n, c.cas_n, c.we_n} == code);
   endfunction

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   sdrpw_state_e         state_q;
   sdrpw_state_e         state_d;
   logic [1:0]           init_cnt_q;
   logic [1:0]           init_cnt_d;
   // row counter only moves in self refresh; row timer counts there and clears on entry to it
   logic [ICW-1:0]       tmr_q;
   logic [ICW-1:0]       tmr_d;
   logic [ROWS_W-1:0]    row_q;
   logic [ROWS_W-1:0]    row_d;
   logic                 tick_d;
   logic                 tick_q;
   logic                 accept;

   // commands only sampled while clock-enable high in the previous cycle
   assign accept = cke_p_q && (state_q != SDRPW_ST_POWER_DOWN)
                   && (state_q != SDRPW_ST_SELF_REFRESH);

   // in the normal state a falling clock-enable picks self refresh or power-down
   // from the command that arrives together with it
   always_comb begin
      state_d    = state_q;
      init_cnt_d = init_cnt_q;
      tmr_d      = tmr_q;
      row_d      = row_q;
      tick_d     = 1'b0;
      case (state_q)
         SDRPW_ST_UNINIT: begin
            if (accept && is_cmd(cmd_s_q, `SDRPW_CMD_REFRESH)) begin
               if (init_cnt_q == 2'(`SDRPW_INIT_REFRESHES - 1)) begin
                  state_d = SDRPW_ST_NORMAL;
               end
               // counter stops once the state leaves the uninitialised state
               init_cnt_d = init_cnt_q + 2'd1;
            end
         end
         SDRPW_ST_NORMAL: begin
            if (!cke_s_q && cke_p_q) begin
               if (is_cmd(cmd_s_q, `SDRPW_CMD_REFRESH)) begin
                  state_d = SDRPW_ST_SELF_REFRESH;
                  tmr_d   = '0;
               end else begin
                  state_d = SDRPW_ST_POWER_DOWN;
               end
            end
         end
         SDRPW_ST_POWER_DOWN: begin
            // input buffers gated: only clock-enable is watched
            if (cke_s_q) begin
               state_d = SDRPW_ST_NORMAL;
            end
         end
         SDRPW_ST_SELF_REFRESH: begin
            // internal timer steps the row counter with no commands
            if (tmr_q == ICW'(ROW_INTERVAL - 1)) begin
               tmr_d  = '0;
               row_d  = row_q + ROWS_W'(1);
               tick_d = 1'b1;
            end else begin
               tmr_d = tmr_q + ICW'(1);
            end
            if (cke_s_q) begin
               state_d = SDRPW_ST_NORMAL;
            end
         end
         default: state_d = SDRPW_ST_UNINIT;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q    <= SDRPW_ST_UNINIT;
         init_cnt_q <= '0;
         tmr_q      <= '0;
         row_q      <= '0;
         tick_q     <= 1'b0;
      end else begin
         state_q    <= state_d;
         init_cnt_q <= init_cnt_d;
         tmr_q      <= tmr_d;
         row_q      <= row_d;
         tick_q     <= tick_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // this block never drives read data, so the data pins stay parked
   assign dq_oe               = 1'b0;
   assign cmd_accept          = accept;
   assign cmd_seen            = cmd_s_q;
   assign self_refresh_active = (state_q == SDRPW_ST_SELF_REFRESH);
   assign power_down_active   = (state_q == SDRPW_ST_POWER_DOWN);
   assign refresh_tick        = tick_q;
   assign refresh_row         = row_q;
   assign init_done           = (state_q != SDRPW_ST_UNINIT);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // checks sleep during reset; pin changes reach them two edges late
   chk_dq_highz: assert property (@(posedge core_clk) disable iff (rst)
      !dq_oe) else $error("data outputs driven");

   chk_pd_gate: assert property (@(posedge core_clk) disable iff (rst)
      power_down_active |-> !cmd_accept) else $error("command taken in power-down");

   chk_pd_enter: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == SDRPW_ST_NORMAL && !cke_s_q && cke_p_q
       && !is_cmd(cmd_s_q, `SDRPW_CMD_REFRESH)) |=> power_down_active)
      else $error("power-down not entered");

   chk_pd_exit: assert property (@(posedge core_clk) disable iff (rst)
      (power_down_active && cke_s_q) |=> !power_down_active)
      else $error("power-down not left");

   chk_sr_enter: assert property (@(posedge core_clk) disable iff (rst)
      (state_q == SDRPW_ST_NORMAL && !cke_s_q && cke_p_q
       && is_cmd(cmd_s_q, `SDRPW_CMD_REFRESH)) |=> self_refresh_active)
      else $error("self refresh not entered");

   chk_sr_gate: assert property (@(posedge core_clk) disable iff (rst)
      self_refresh_active |-> !cmd_accept) else $error("command taken in self refresh");

   chk_sr_row: assert property (@(posedge core_clk) disable iff (rst)
      (self_refresh_active && tmr_q == ICW'(ROW_INTERVAL - 1))
      |=> (refresh_tick && refresh_row == $past(refresh_row) + ROWS_W'(1)))
      else $error("self refresh row not advanced");

   chk_sr_hold: assert property (@(posedge core_clk) disable iff (rst)
      (self_refresh_active && tmr_q != ICW'(ROW_INTERVAL - 1)) |=> !refresh_tick)
      else $error("spurious refresh tick");

   chk_row_step: assert property (@(posedge core_clk) disable iff (rst)
      $changed(refresh_row) |-> refresh_tick)
      else $error("row counter moved without a tick");

   chk_tick_src: assert property (@(posedge core_clk) disable iff (rst)
      refresh_tick |-> $past(self_refresh_active))
      else $error("refresh tick outside self refresh");

   chk_sr_exit: assert property (@(posedge core_clk) disable iff (rst)
      (self_refresh_active && cke_s_q) |=> !self_refresh_active)
      else $error("self refresh not left");
endmodule

// >>> hdl/sdrpw_map.svh
// sdram power/refresh block: timing counts and command codes
// assumes a 100 MHz core clock
`ifndef SDRPW_MAP_SVH
`define SDRPW_MAP_SVH
`define SDRPW_CLK_PERIOD_NS 10
`define SDRPW_POWERUP_WAIT_US 100
`define SDRPW_POWERUP_WAIT_CYC ((`SDRPW_POWERUP_WAIT_US * 1000 + `SDRPW_CLK_PERIOD_NS - 1) / `SDRPW_CLK_PERIOD_NS)
`define SDRPW_XSR_NS 70
`define SDRPW_XSR_CYC ((`SDRPW_XSR_NS + `SDRPW_CLK_PERIOD_NS - 1) / `SDRPW_CLK_PERIOD_NS)
`define SDRPW_REFRESH_INTERVAL_MS 64
`define SDRPW_ROWS 4096
`define SDRPW_ROW_INTERVAL_CYC ((`SDRPW_REFRESH_INTERVAL_MS * 1000000 / `SDRPW_ROWS) / `SDRPW_CLK_PERIOD_NS)
`define SDRPW_INIT_REFRESHES 2
`define SDRPW_CMD_NOP 4'b0111
`define SDRPW_CMD_ACTIVE 4'b0011
`define SDRPW_CMD_REFRESH 4'b0001
`define SDRPW_CMD_PRECHARGE 4'b0010
`define SDRPW_CMD_LOAD_MODE 4'b0000
`endif

// >>> hdl/sdrpw_pkg.sv
// sdram power/refresh block: shared types
// assumes sdrpw_map.svh holds numeric constants
package sdrpw_pkg;
   typedef enum logic [1:0] {
      SDRPW_ST_UNINIT,
      SDRPW_ST_NORMAL,
      SDRPW_ST_POWER_DOWN,
      SDRPW_ST_SELF_REFRESH
   } sdrpw_state_e;

   // cs_n, ras_n, cas_n, we_n in that order
   typedef struct packed {
      logic       cs_n;
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
   } sdrpw_cmd_s;
endpackage

// >>> verif/sdrpw_ctrl_model.sv
// controller model: drives clock-enable and command pins
// assumes the bench calls its tasks from the core clock domain
`timescale 1ns/1ps
module sdrpw_ctrl_model
   import sdrpw_pkg::*;
(
   input  wire logic             core_clk,
   output logic                  cke_pin,
   output sdrpw_pkg::sdrpw_cmd_s cmd_pin
);
   import sdrpw_pkg::*;
   initial begin
      cke_pin = 1'b1;
      cmd_pin = 4'hF;
   end
   // one command for one clock, then deselect
   task automatic issue(input logic [3:0] c, input logic cke);
      @(posedge core_clk);
      cmd_pin <= c;
      cke_pin <= cke;
      @(posedge core_clk);
      cmd_pin <= 4'hF;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask
endmodule

// >>> verif/sdrpw_core_test.sv
// bench for the power/refresh block
// assumes the controller model drives the pins
`timescale 1ns/1ps
`include "sdrpw_map.svh"
module sdrpw_core_test;
   import sdrpw_pkg::*;
   localparam int RI = 4;
   // two recovery clocks cover any recovery time up to two clocks
   localparam int         WR_REC_CYC          = 2;
   localparam logic [3:0] CMD_WRITE           = 4'h4;
   localparam longint     REFRESH_INTERVAL_NS = `SDRPW_REFRESH_INTERVAL_MS * 1000000;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        cke_pin, dq_oe, cmd_accept, sr_on, pd_on, tick, init_done;
   sdrpw_cmd_s  cmd_pin, cmd_seen;
   logic [11:0] row, r0;
   int          err_total = 0;
   int          total_checks = 0;
   int          n;
   always #5 core_clk = ~core_clk;
   sdrpw_ctrl_model u_ctrl (.core_clk(core_clk), .cke_pin(cke_pin), .cmd_pin(cmd_pin));
   sdrpw_core #(.ROW_INTERVAL(RI)) u_dut (
      .core_clk(core_clk), .rst(rst), .cke_pin(cke_pin), .cmd_pin(cmd_pin),
      .dq_oe(dq_oe), .cmd_accept(cmd_accept), .cmd_seen(cmd_seen),
      .self_refresh_active(sr_on), .power_down_active(pd_on),
      .refresh_tick(tick), .refresh_row(row), .init_done(init_done));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask
   task automatic wait_tick();
      n = 0;
      while (tick !== 1'b1 && n < 4 * RI) begin
         step();
         n++;
      end
      if (tick !== 1'b1) begin
         check(12'h000, 12'h001);
         print_verdict();
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_init();
      u_ctrl.idle(`SDRPW_POWERUP_WAIT_CYC);
      u_ctrl.issue(`SDRPW_CMD_LOAD_MODE, 1'b1);
      u_ctrl.issue(`SDRPW_CMD_REFRESH, 1'b1);
      u_ctrl.idle(3);
      #1 check(init_done, 1'b0);
      u_ctrl.issue(`SDRPW_CMD_REFRESH, 1'b1);
      u_ctrl.idle(3);
      #1 check(init_done, 1'b1);
      check(dq_oe, 1'b0);
      $display("test init done");
   endtask
   task automatic t_self_refresh();
      u_ctrl.issue(`SDRPW_CMD_REFRESH, 1'b0);
      step();
      check(sr_on, 1'b0);
      step();
      check(sr_on, 1'b1);
      check(cmd_accept, 1'b0);
      wait_tick();
      r0 = row;
      step();
      wait_tick();
      check(12'(n + 1), 12'(RI));
      check(row, r0 + 12'h001);
      u_ctrl.issue(`SDRPW_CMD_NOP, 1'b1);
      u_ctrl.idle(`SDRPW_XSR_CYC);
      #1 check(sr_on, 1'b0);
      $display("test self refresh done");
   endtask
   task automatic t_power_down();
      u_ctrl.issue(`SDRPW_CMD_ACTIVE, 1'b1);
      u_ctrl.issue(CMD_WRITE, 1'b1);
      step();
      check(cmd_seen, CMD_WRITE);
      check(cmd_accept, 1'b1);
      u_ctrl.idle(WR_REC_CYC);
      u_ctrl.issue(`SDRPW_CMD_PRECHARGE, 1'b1);
      u_ctrl.idle(2);
      u_ctrl.issue(`SDRPW_CMD_NOP, 1'b0);
      u_ctrl.idle(2);
      #1 check(pd_on, 1'b1);
      u_ctrl.issue(`SDRPW_CMD_ACTIVE, 1'b0);
      repeat (4) begin
         step();
         check(cmd_accept, 1'b0);
      end
      u_ctrl.issue(`SDRPW_CMD_NOP, 1'b1);
      u_ctrl.idle(3);
      #1 check(pd_on, 1'b0);
      u_ctrl.issue(`SDRPW_CMD_ACTIVE, 1'b1);
      step();
      check(cmd_seen, `SDRPW_CMD_ACTIVE);
      check(cmd_accept, 1'b1);
      u_ctrl.issue(`SDRPW_CMD_ACTIVE, 1'b1);
      step();
      check(cmd_seen, `SDRPW_CMD_ACTIVE);
      $display("test power down done");
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_init();
      t_self_refresh();
      t_power_down();
      check(12'($time >= REFRESH_INTERVAL_NS), 12'h000);
      print_verdict();
   end
endmodule
